// *** rtl/ess_status_stats.sv ***
// Status flags and frame statistics of the Ethernet controller, behind a plain register port.
// Assumes the engines drive synchronous activity levels and one-cycle event pulses on core_clk.
//
// Notes on behaviour
// - Tx active bit 6 follows transmit activity.
// - Tx active falls on any transmit end.
// - Rx active bit 5 follows receive activity.
// - Rx active falls on any receive end.
// - The tx and rx active flags each see only their direction.
// - Module enable bit 15 low forces the tx and rx active flags zero.
// - Status bits 4 to 0 read zero.
// - Counts in bits 15-0, upper bits zero.
// - Dropped counter counts overrun-dropped filtered frames.
// - Each overrun drop sets interrupt bit 0.
// - Good transmit counter counts successful frames.
// - One-collision counter counts second-try successes.
// - Reading a counter clears it unless bytes 0/1 off.
// - Counters are zero after reset.
// - Overrun flag holds until reset or clear.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module ess_status_stats
	import ess_pkg::*;
(
	// Clock, reset and freeze.
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// Register port.
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic [3:0] reg_be,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Engine activity levels.
	input wire logic tx_engine_busy,
	input wire logic rx_engine_busy,
	// Engine event pulses.
	input wire logic rx_overrun_drop,
	input wire logic tx_frame_ok,
	input wire logic tx_frame_one_col,
	// State seen by the rest of the controller.
	output logic module_on,
	output logic tx_active_flag,
	output logic rx_active_flag,
	output logic module_active_flag,
	output logic rx_fifo_overrun_flag
);

	// Address decode pieces.
	logic [3:0] grp; // Register group.
	ess_wop_e wop; // Alias kind of the access.
	logic [15:0] wmask; // Byte-lane mask over the implemented low half.
	logic low_lanes; // Byte 0 or byte 1 enabled.

	// Next values of the control and flag state.
	logic next_module_on;
	logic next_tx_active;
	logic next_rx_active;
	logic next_module_active;
	logic next_overrun;
	logic [DATA_W-1:0] next_rdata;

	// Statistics counters, one slot per counter.
	logic [NUM_STATS-1:0] stat_inc; // Event into each counter.
	logic [NUM_STATS-1:0] stat_hit; // Access falls on each counter group.
	logic [15:0] stat_count [NUM_STATS]; // Current counts.

	// Split the address; the low two bits are ignored as accesses are word aligned.
	always_comb begin
		grp = reg_addr[7:4];
		wop = ess_wop_e'(reg_addr[3:2]);
		wmask = {{8{reg_be[1]}}, {8{reg_be[0]}}};
		low_lanes = reg_be[0] | reg_be[1];
	end

	// Route each engine event to its own counter.
	always_comb begin
		stat_inc = '0;
		stat_inc[STAT_DROPPED] = rx_overrun_drop;
		stat_inc[STAT_TX_GOOD] = tx_frame_ok;
		stat_inc[STAT_ONE_COL] = tx_frame_one_col;
	end

	// One counter per statistics register, each in its own 16-byte group.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_STATS; gi++) begin : g_stat
			// Group number of this counter.
			assign stat_hit[gi] = (grp == GRP_STAT_BASE + 4'(gi));

			// Reads clear only at the main address, and only with byte 0 or 1 enabled.
			ess_stat_counter u_cnt (
				.core_clk(core_clk),
				.rst(rst),
				.ce(ce),
				.inc(stat_inc[gi]),
				.rd_clear(reg_rd & stat_hit[gi] & (wop == WOP_PLAIN) & low_lanes),
				.wr_en(reg_wr & stat_hit[gi]),
				.wr_op(wop),
				.wr_data(reg_wdata[15:0]),
				.wr_mask(wmask),
				.count(stat_count[gi])
			);
		end
	endgenerate

	// Control register: only the module enable bit is held here.
	always_comb begin
		logic [15:0] img;
		img = 16'h0000;
		img[BIT_MODULE_ON] = module_on;
		next_module_on = module_on;
		if (reg_wr && grp == GRP_CONTROL) begin
			img = ess_apply_wop(img, reg_wdata[15:0], wmask, wop);
			next_module_on = img[BIT_MODULE_ON];
		end
	end

	// Activity flags are sampled from the engines, so they lag activity by one cycle.
	// The tx and rx flags each look only at their own engine and are forced low while the module is off.
	always_comb begin
		next_tx_active = module_on & tx_engine_busy;
		next_rx_active = module_on & rx_engine_busy;
		// The module stays busy while enabled or while an engine finishes after switch-off.
		next_module_active = module_on | tx_engine_busy | rx_engine_busy;
	end

	// Overrun flag: software may write it through any alias, but a drop in the same
	// cycle wins, because losing an overflow report would hide lost frames.
	always_comb begin
		logic [15:0] img;
		img = 16'h0000;
		img[BIT_RX_OVERRUN] = rx_fifo_overrun_flag;
		next_overrun = rx_fifo_overrun_flag;
		if (reg_wr && grp == GRP_IRQ) begin
			img = ess_apply_wop(img, reg_wdata[15:0], wmask, wop);
			next_overrun = img[BIT_RX_OVERRUN];
		end
		if (rx_overrun_drop) begin
			next_overrun = 1'b1;
		end
	end

	// Read data for the cycle after the strobe; alias and unmapped addresses read zero.
	always_comb begin
		next_rdata = RD_IDLE;
		if (reg_rd && wop == WOP_PLAIN) begin
			case (grp)
				GRP_STATUS: begin
					// Low five bits and everything above bit 7 stay zero.
					next_rdata[BIT_MODULE_ACTIVE] = module_active_flag;
					next_rdata[BIT_TX_ACTIVE] = tx_active_flag;
					next_rdata[BIT_RX_ACTIVE] = rx_active_flag;
				end
				GRP_CONTROL: begin
					next_rdata[BIT_MODULE_ON] = module_on;
				end
				GRP_IRQ: begin
					next_rdata[BIT_RX_OVERRUN] = rx_fifo_overrun_flag;
				end
				default: begin
					// Counters show the value before any clear of this same read.
					for (int i = 0; i < NUM_STATS; i++) begin
						if (stat_hit[i]) begin
							next_rdata = {16'h0000, stat_count[i]};
						end
					end
				end
			endcase
		end
	end

	// Control and flag registers; all outputs come straight from here.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			module_on <= RST_FLAG;
			tx_active_flag <= RST_FLAG;
			rx_active_flag <= RST_FLAG;
			module_active_flag <= RST_FLAG;
			rx_fifo_overrun_flag <= RST_FLAG;
			reg_rdata <= RD_IDLE;
		end else if (ce) begin
			module_on <= next_module_on;
			tx_active_flag <= next_tx_active;
			rx_active_flag <= next_rx_active;
			module_active_flag <= next_module_active;
			rx_fifo_overrun_flag <= next_overrun;
			reg_rdata <= next_rdata;
		end
	end

endmodule

// *** rtl/ess_pkg.sv ***
// Shared constants, types and the alias-write helper for the status and statistics block.
// Assumes a plain word-addressed register port with byte enables and one clock domain.
package ess_pkg;

	// Register port widths, counter width and number of counters.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int NUM_STATS = 3;

	// Each register owns a 16-byte group; addr[7:4] picks the group.
	localparam logic [3:0] GRP_STATUS = 4'h0;
	localparam logic [3:0] GRP_STAT_BASE = 4'h1;
	localparam logic [3:0] GRP_CONTROL = 4'h4;
	localparam logic [3:0] GRP_IRQ = 4'h5;

	// Byte offsets of the main registers; +4, +8, +C are the set, clear and invert aliases.
	localparam logic [7:0] OFS_CONTROLLER_STATUS = 8'h00;
	localparam logic [7:0] OFS_RX_DROPPED_FRAME_STAT = 8'h10;
	localparam logic [7:0] OFS_TX_GOOD_FRAME_STAT = 8'h20;
	localparam logic [7:0] OFS_TX_ONE_COLLISION_STAT = 8'h30;
	localparam logic [7:0] OFS_CONTROL_REG_ONE = 8'h40;
	localparam logic [7:0] OFS_INTERRUPT_FLAG_REG = 8'h50;

	// Counter slot order inside the statistics array.
	localparam int STAT_DROPPED = 0;
	localparam int STAT_TX_GOOD = 1;
	localparam int STAT_ONE_COL = 2;

	// Field positions.
	localparam int BIT_MODULE_ACTIVE = 7;
	localparam int BIT_TX_ACTIVE = 6;
	localparam int BIT_RX_ACTIVE = 5;
	localparam int BIT_MODULE_ON = 15;
	localparam int BIT_RX_OVERRUN = 0;

	// Values after reset.
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic RST_FLAG = 1'b0;
	localparam logic [31:0] RD_IDLE = 32'h0000_0000;

	// Kind of write selected by addr[3:2].
	typedef enum logic [1:0] {
		WOP_PLAIN,
		WOP_SET,
		WOP_CLEAR,
		WOP_INVERT
	} ess_wop_e;

	// Applies a byte-masked plain, set, clear or invert write to a 16-bit register image.
	function automatic logic [15:0] ess_apply_wop(input logic [15:0] old, input logic [15:0] din,
			input logic [15:0] mask, input ess_wop_e op);
		logic [15:0] d;
		d = din & mask;
		case (op)
			WOP_PLAIN: ess_apply_wop = (old & ~mask) | d;
			WOP_SET: ess_apply_wop = old | d;
			WOP_CLEAR: ess_apply_wop = old & ~d;
			default: ess_apply_wop = old ^ d;
		endcase
	endfunction

endpackage

// *** rtl/ess_stat_counter.sv ***
// One clear-on-read 16-bit frame statistics counter with alias writes.
// Assumes the parent decodes the address and qualifies the read clear with byte enables.
`timescale 1ns/1ns
module ess_stat_counter
	import ess_pkg::*;
(
	// Clock, reset and freeze.
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// Counting event, one pulse per frame.
	input wire logic inc,
	// Clearing read of this register.
	input wire logic rd_clear,
	// Alias write of this register.
	input wire logic wr_en,
	input wire ess_wop_e wr_op,
	input wire logic [15:0] wr_data,
	input wire logic [15:0] wr_mask,
	// Current count.
	output logic [15:0] count
);

	logic [15:0] next_count; // Value for the next edge.

	// Write first, then the read clear, then the event, so an event is never swallowed.
	always_comb begin
		next_count = count;
		if (wr_en) begin
			next_count = ess_apply_wop(count, wr_data, wr_mask, wr_op);
		end
		if (rd_clear) begin
			next_count = RST_COUNT;
		end
		if (inc) begin
			// Plain 16-bit add wraps from all ones to zero; read plus event leaves one.
			next_count = next_count + 16'h0001;
		end
	end

	// Count register, zero after reset and frozen while ce is low.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count <= RST_COUNT;
		end else if (ce) begin
			count <= next_count;
		end
	end

endmodule

// *** dv/ess_status_stats_chk.sv ***
// Assertion checker for the status and statistics block.
// Sees only the top module's ports; one clock domain, bound at the foot.
`timescale 1ns/1ns
module ess_status_stats_chk
	import ess_pkg::*;
(
	// Clock, reset and freeze.
	input wire logic core_clk, rst, ce,
	// Register port.
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata, reg_rdata,
	input wire logic [3:0] reg_be,
	input wire logic reg_wr, reg_rd,
	// Engine side and flags.
	input wire logic tx_engine_busy, rx_engine_busy, rx_overrun_drop, tx_frame_ok, tx_frame_one_col,
	input wire logic module_on, tx_active_flag, rx_active_flag, module_active_flag, rx_fifo_overrun_flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// A plain read of the good-transmit counter that clears it.
	sequence s_rd;
		ce && reg_rd && reg_addr == OFS_TX_GOOD_FRAME_STAT && reg_be[1:0] != 2'h0;
	endsequence
	// Each flag follows only its own engine, gated by the enable.
	property p_tx; ce |=> tx_active_flag == $past(module_on && tx_engine_busy); endproperty
	a_tx: assert property (p_tx) else $error("tx flag wrong");
	property p_rx; ce |=> rx_active_flag == $past(module_on && rx_engine_busy); endproperty
	a_rx: assert property (p_rx) else $error("rx flag wrong");
	property p_off; ce && !module_on |=> !tx_active_flag && !rx_active_flag; endproperty
	a_off: assert property (p_off) else $error("flag high while off");
	// Only a status read shows the unimplemented low bits; counters and flags use them.
	property p_lo; ce && reg_rd && reg_addr == OFS_CONTROLLER_STATUS |=> reg_rdata[4:0] == 5'h00; endproperty
	a_lo: assert property (p_lo) else $error("low status bits set");
	property p_hi; reg_rdata[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper bits set");
	property p_ovr; ce && rx_overrun_drop |=> rx_fifo_overrun_flag; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun flag not set");
	// Only a write to the interrupt group may take the sticky flag down.
	property p_hold; ce && rx_fifo_overrun_flag && !(reg_wr && reg_addr[7:4] == GRP_IRQ) |=> rx_fifo_overrun_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("overrun flag lost");
	property p_idle; ce && !reg_rd |=> reg_rdata == RD_IDLE; endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	// Back-to-back reads: the second sees only an event of the first read cycle.
	property p_clr; s_rd ##1 s_rd |=> reg_rdata == {31'h0, $past(tx_frame_ok, 2)}; endproperty
	a_clr: assert property (p_clr) else $error("clear on read wrong");
	c_b2b: cover property (s_rd ##1 s_rd);
	c_both: cover property (tx_active_flag && module_active_flag);
	c_ovr: cover property ($rose(rx_fifo_overrun_flag));
endmodule

bind ess_status_stats ess_status_stats_chk i_chk (.*);

// *** dv/test_ess_status_stats.sv ***
// Self-checking bench for the status and statistics block.
// Drives every port at the rising edge; ce is dropped once to check that state freezes.
`timescale 1ns/1ns
module test_ess_status_stats
	import ess_pkg::*;
;
	logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic tx_engine_busy = 1'b0, rx_engine_busy = 1'b0, rx_overrun_drop = 1'b0, tx_frame_ok = 1'b0;
	logic tx_frame_one_col = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
	logic [3:0] reg_be = 4'h0;
	logic module_on, tx_active_flag, rx_active_flag, module_active_flag, rx_fifo_overrun_flag;
	int n_fail = 0, checks_done = 0;
	// Rows of address, byte enables and expected read data.
	logic [43:0] rows [9] = '{{8'h10, 4'hC, 32'h3}, {8'h10, 4'h3, 32'h3}, {8'h10, 4'h1, 32'h0},
		{8'h20, 4'h2, 32'h2}, {8'h20, 4'h3, 32'h0}, {8'h30, 4'h3, 32'h1}, {8'h30, 4'h3, 32'h0},
		{8'h60, 4'h3, 32'h0}, {8'h14, 4'h3, 32'h0}};
	always #20 core_clk = ~core_clk;
	ess_status_stats i_ess_status_stats (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t data %h expected %h", $time, got, exp);
		end
	endtask
	// Flags packed as module active, tx, rx, overrun.
	task automatic chkf(input logic [3:0] exp);
		chk({28'h0, module_active_flag, tx_active_flag, rx_active_flag, rx_fifo_overrun_flag}, {28'h0, exp});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] b);
		reg_addr <= a;
		reg_wdata <= v;
		reg_be <= b;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [3:0] b, input logic [31:0] e);
		reg_addr <= a;
		reg_be <= b;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		chk(reg_rdata, e);
	endtask
	// Event pulses: dropped, good, one collision.
	task automatic ev(input logic [2:0] p);
		{rx_overrun_drop, tx_frame_ok, tx_frame_one_col} <= p;
		@(posedge core_clk);
	endtask
	task automatic results;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		results;
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 1; i < 4; i++) rd(8'(i * 16), 4'h3, 32'h0);
		$display("reset test done");
		wr(OFS_CONTROL_REG_ONE, 32'h8000, 4'h3);
		tx_engine_busy <= 1'b1;
		repeat (2) @(posedge core_clk);
		chkf(4'hC);
		chk({31'h0, module_on}, 32'h1);
		tx_engine_busy <= 1'b0;
		rx_engine_busy <= 1'b1;
		repeat (2) @(posedge core_clk);
		chkf(4'hA);
		rd(OFS_CONTROLLER_STATUS, 4'hF, 32'h0000_00A0);
		tx_engine_busy <= 1'b1;
		wr(OFS_CONTROL_REG_ONE, 32'h0, 4'h3);
		repeat (2) @(posedge core_clk);
		chkf(4'h8);
		chk({31'h0, module_on}, 32'h0);
		tx_engine_busy <= 1'b0;
		rx_engine_busy <= 1'b0;
		$display("flag test done");
		ev(3'h7);
		ev(3'h6);
		ev(3'h4);
		ev(3'h0);
		chkf(4'h1);
		foreach (rows[i]) rd(rows[i][43:36], rows[i][35:32], rows[i][31:0]);
		$display("counter rows done");
		// A frame counted in the clearing read's own cycle must survive.
		reg_addr <= OFS_TX_GOOD_FRAME_STAT;
		reg_be <= 4'h3;
		reg_rd <= 1'b1;
		tx_frame_ok <= 1'b1;
		@(posedge core_clk);
		tx_frame_ok <= 1'b0;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		chk(reg_rdata, 32'h0);
		@(posedge core_clk);
		chk(reg_rdata, 32'h1);
		rd(OFS_TX_GOOD_FRAME_STAT, 4'h3, 32'h0);
		wr(OFS_TX_ONE_COLLISION_STAT, 32'hFFFF, 4'h3);
		ev(3'h1);
		ev(3'h0);
		rd(OFS_TX_ONE_COLLISION_STAT, 4'h3, 32'h0);
		wr(OFS_CONTROL_REG_ONE, 32'h0, 4'h3);
		@(posedge core_clk);
		chkf(4'h1);
		wr(OFS_INTERRUPT_FLAG_REG + 8'h08, 32'h1, 4'h1);
		@(posedge core_clk);
		chkf(4'h0);
		// Software debug access goes through the set and clear aliases of the good-transmit counter.
		wr(OFS_TX_GOOD_FRAME_STAT + 8'h04, 32'h5, 4'h3);
		wr(OFS_TX_GOOD_FRAME_STAT + 8'h08, 32'h1, 4'h3);
		rd(OFS_TX_GOOD_FRAME_STAT, 4'h3, 32'h4);
		// A frame pulse while ce is low must not be counted.
		ce <= 1'b0;
		tx_frame_ok <= 1'b1;
		@(posedge core_clk);
		tx_frame_ok <= 1'b0;
		ce <= 1'b1;
		rd(OFS_TX_GOOD_FRAME_STAT, 4'h3, 32'h0);
		$display("awkward cases done");
		results;
	end
endmodule
